// *** hw/sgwl_pkg.sv ***
// Constants shared by the serial gain word loader
// How it works
// - A gain load shifts any number of data bits into an eight-bit shift register; the last eight are kept.
// - A falling load-window enable opens the load and lets serial clock pulses shift.
// - While open, data is sampled on each rising serial clock edge, most significant bit first.
// - A rising load-window enable copies the eight-bit shifted word into the gain latch.
// - Gain runs from -18.16 dB at code zero to +30 dB at code 128, 6.02 dB per bit position.
// - While the window is open the old gain stays applied; after it closes shifting is blocked.
// - After reset the gain latch holds code zero, the minimum gain.
// - Transmit-on is held low until the gain is programmed, then raised; high enables output.
package sgwl_pkg;
	localparam int         SGWL_WORD_W        = 8;
	localparam logic [7:0] SGWL_GAIN_RST      = 8'h00;
	// Window pin idles high; its flops reset there so no false rise follows reset
	localparam logic       SGWL_WIN_IDLE      = 1'h1;
	// Gain in centi-dB, signed
	localparam int         SGWL_GAIN_MIN_CDB  = -1816;
	localparam int         SGWL_GAIN_STEP_CDB = 602;
	localparam int         SGWL_GAIN_W        = 16;
endpackage : sgwl_pkg

// *** hw/sgwl_sync.sv ***
// Two-flop synchroniser for one pin
`timescale 1ns/1ps
module sgwl_sync #(
	parameter logic RST_VAL = 1'h0
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sgwl_sync_t;
	sgwl_sync_t st_q;
	sgwl_sync_t st_d;
	always_comb begin
		st_d    = st_q;
		st_d.s1 = d_i;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= {RST_VAL, RST_VAL};
		end else begin
			st_q <= st_d;
		end
	end
	assign q_o = st_q.s2;
endmodule : sgwl_sync

// *** hw/sgwl_loader.sv ***
// Serial gain word loader: shift register, gain latch, gain map
`timescale 1ns/1ps
module sgwl_loader
	import sgwl_pkg::*;
(
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     serial_clk_i,
	input  wire logic                     serial_gain_data_i,
	input  wire logic                     load_window_enable_i,
	input  wire logic                     transmit_on_i,
	output logic        [SGWL_WORD_W-1:0] gain_code_o,
	output logic signed [SGWL_GAIN_W-1:0] gain_cdb_o,
	output logic                          tx_active_o,
	output logic                          load_done_o
);
	logic sclk_s;
	logic sdat_s;
	logic den_s;
	logic transmit_on_s;

	// Clock and data share the same two-flop delay, so pin set-up carries over
	sgwl_sync u_sclk (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.d_i   (serial_clk_i),
		.q_o   (sclk_s)
	);
	sgwl_sync u_sdat (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.d_i   (serial_gain_data_i),
		.q_o   (sdat_s)
	);
	// Resets to the idle high level, else release looks like a window close
	sgwl_sync #(
		.RST_VAL (SGWL_WIN_IDLE)
	) u_den (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.d_i   (load_window_enable_i),
		.q_o   (den_s)
	);
	sgwl_sync u_transmit_on (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.d_i   (transmit_on_i),
		.q_o   (transmit_on_s)
	);

	typedef struct packed {
		logic                          sclk_prev;
		logic                          den_prev;
		logic [SGWL_WORD_W-1:0]        shift;
		logic [SGWL_WORD_W-1:0]        gain;
		logic signed [SGWL_GAIN_W-1:0] cdb;
		logic                          tx;
		logic                          done;
	} sgwl_state_t;

	sgwl_state_t st_q;
	sgwl_state_t st_d;

	// Position of highest set bit, plus one; zero for code zero
	// Mixed codes take their highest bit; only single-bit codes are tabulated
	function automatic logic [3:0] sgwl_msb_pos(input logic [SGWL_WORD_W-1:0] c);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < SGWL_WORD_W; i++) begin
			if (c[i]) begin
				p = 4'(i + 1);
			end
		end
		return p;
	endfunction : sgwl_msb_pos

	logic sclk_rise;
	logic den_rise;
	assign sclk_rise = sclk_s & ~st_q.sclk_prev;
	assign den_rise  = den_s & ~st_q.den_prev;

	always_comb begin
		st_d           = st_q;
		st_d.sclk_prev = sclk_s;
		st_d.den_prev  = den_s;
		st_d.done      = 1'h0;
		// Shift only while window low; a high window blocks shifting
		if (!den_s && sclk_rise) begin
			st_d.shift = {st_q.shift[SGWL_WORD_W-2:0], sdat_s};
		end
		if (den_rise) begin
			st_d.gain = st_q.shift;
			st_d.cdb  = SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB
				+ SGWL_GAIN_STEP_CDB * int'(sgwl_msb_pos(st_q.shift)));
			st_d.done = 1'h1;
		end
		// Output disabled while transmit-on low
		st_d.tx = transmit_on_s;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_q      <= '0;
			st_q.den_prev <= SGWL_WIN_IDLE;
			st_q.gain <= SGWL_GAIN_RST;
			st_q.cdb  <= SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB);
		end else begin
			st_q <= st_d;
		end
	end

	assign gain_code_o = st_q.gain;
	assign gain_cdb_o  = st_q.cdb;
	assign tx_active_o = st_q.tx;
	assign load_done_o = st_q.done;

	property p_gain_hold;
		@(posedge mclk_i) disable iff (rst_i)
		!load_done_o |-> $stable(gain_code_o);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("Gain changed without load");

	property p_load_copy;
		@(posedge mclk_i) disable iff (rst_i)
		den_rise |=> (gain_code_o == $past(st_q.shift)) && load_done_o;
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("Load did not copy word");

	property p_shift_msb;
		@(posedge mclk_i) disable iff (rst_i)
		(!den_s && sclk_rise) |=> st_q.shift == {$past(st_q.shift[6:0]), $past(sdat_s)};
	endproperty
	a_shift_msb: assert property (p_shift_msb) else $error("Shift wrong");

	property p_shift_block;
		@(posedge mclk_i) disable iff (rst_i)
		den_s |=> $stable(st_q.shift);
	endproperty
	a_shift_block: assert property (p_shift_block) else $error("Shift while closed");

	property p_zero_gain;
		@(posedge mclk_i) disable iff (rst_i)
		gain_code_o == '0 |-> gain_cdb_o == SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB);
	endproperty
	a_zero_gain: assert property (p_zero_gain) else $error("Code zero gain wrong");

	property p_top_gain;
		@(posedge mclk_i) disable iff (rst_i)
		gain_code_o[SGWL_WORD_W-1]
			|-> gain_cdb_o == SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB + SGWL_GAIN_STEP_CDB * SGWL_WORD_W);
	endproperty
	a_top_gain: assert property (p_top_gain) else $error("Top gain wrong");

	property p_tx_follow;
		@(posedge mclk_i) disable iff (rst_i)
		transmit_on_s |=> tx_active_o;
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("Transmit not enabled");

	property p_reset_zero;
		@(posedge mclk_i)
		rst_i |=> gain_code_o == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("Reset gain not zero");

	property p_done_pulse;
		@(posedge mclk_i) disable iff (rst_i)
		load_done_o |=> !load_done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("Load pulse too long");

	property p_done_cause;
		@(posedge mclk_i) disable iff (rst_i)
		load_done_o |-> $past(den_rise);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("Load without close");

	property p_gain_open;
		@(posedge mclk_i) disable iff (rst_i)
		!den_s |=> $stable(gain_code_o);
	endproperty
	a_gain_open: assert property (p_gain_open) else $error("Gain moved in window");

	property p_cdb_hold;
		@(posedge mclk_i) disable iff (rst_i)
		!load_done_o |-> $stable(gain_cdb_o);
	endproperty
	a_cdb_hold: assert property (p_cdb_hold) else $error("Gain value moved");

	property p_shift_idle;
		@(posedge mclk_i) disable iff (rst_i)
		!sclk_rise |=> $stable(st_q.shift);
	endproperty
	a_shift_idle: assert property (p_shift_idle) else $error("Shift without clock");

	property p_tx_low;
		@(posedge mclk_i) disable iff (rst_i)
		!transmit_on_s |=> !tx_active_o;
	endproperty
	a_tx_low: assert property (p_tx_low) else $error("Transmit not disabled");

	property p_reset_quiet;
		@(posedge mclk_i)
		rst_i |=> (gain_cdb_o == SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB)) && !tx_active_o && !load_done_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("Reset outputs wrong");

	property p_cdb_range;
		@(posedge mclk_i) disable iff (rst_i)
		(gain_cdb_o >= SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB))
			&& (gain_cdb_o <= SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB + SGWL_GAIN_STEP_CDB * SGWL_WORD_W));
	endproperty
	a_cdb_range: assert property (p_cdb_range) else $error("Gain out of range");

	property p_row_low;
		@(posedge mclk_i) disable iff (rst_i)
		gain_code_o == 8'h01 |-> gain_cdb_o == SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB + SGWL_GAIN_STEP_CDB);
	endproperty
	a_row_low: assert property (p_row_low) else $error("Code one gain wrong");

	property p_row_mid;
		@(posedge mclk_i) disable iff (rst_i)
		gain_code_o == 8'h40
			|-> gain_cdb_o == SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB + SGWL_GAIN_STEP_CDB * (SGWL_WORD_W - 1));
	endproperty
	a_row_mid: assert property (p_row_mid) else $error("Code 64 gain wrong");
endmodule : sgwl_loader

// *** verif/sgwl_host.sv ***
// Host controller model for the serial gain pins
`timescale 1ns/1ps
module sgwl_host (
	input  wire logic mclk_i,
	output logic      sck_o,
	output logic      sd_o,
	output logic      en_o,
	output logic      ton_o
);
	initial begin
		sck_o = 1'h0;
		sd_o  = 1'h0;
		en_o  = 1'h1;
		ton_o = 1'h0;
	end
	// Raised only once the gain is programmed
	task automatic tx(input logic v);
		@(posedge mclk_i) ton_o <= v;
	endtask : tx
	// Clock rests low between frames, 160 ns period inside
	task automatic load(input logic [15:0] w, input int n);
		@(posedge mclk_i) en_o <= 1'h0;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (2) @(posedge mclk_i);
			sd_o <= w[i];
			repeat (2) @(posedge mclk_i);
			sck_o <= 1'h1;
			repeat (4) @(posedge mclk_i);
			sck_o <= 1'h0;
		end
		repeat (2) @(posedge mclk_i);
		en_o <= 1'h1;
		sd_o <= ~sd_o;
	endtask : load
	// Clocks with the window shut, meant to be ignored
	task automatic stray(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge mclk_i);
			sck_o <= 1'h1;
			sd_o <= ~sd_o;
			repeat (4) @(posedge mclk_i);
			sck_o <= 1'h0;
		end
	endtask : stray
endmodule : sgwl_host

// *** verif/testbench.sv ***
// Self-checking bench for the serial gain word loader
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin bad_count++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench
	import sgwl_pkg::*;
();
	logic                   mclk_i = 1'h0;
	logic                   rst_i = 1'h1;
	logic                   sck, sd, en, ton, tx_active_o, load_done_o;
	logic [7:0]             gain_code_o;
	logic signed [SGWL_GAIN_W-1:0] gain_cdb_o;
	logic [7:0]             sr = 8'h00;
	logic [7:0]             q[$];
	logic [31:0]            rs = 32'h0000763d;
	int                     bad_count = 0;
	int                     checked = 0;
	initial forever #10 mclk_i = ~mclk_i;
	sgwl_host HOST (.mclk_i(mclk_i), .sck_o(sck), .sd_o(sd), .en_o(en), .ton_o(ton));
	sgwl_loader DUT (.mclk_i(mclk_i), .rst_i(rst_i), .serial_clk_i(sck),
		.serial_gain_data_i(sd), .load_window_enable_i(en), .transmit_on_i(ton),
		.gain_code_o(gain_code_o), .gain_cdb_o(gain_cdb_o),
		.tx_active_o(tx_active_o), .load_done_o(load_done_o));
	function automatic logic signed [SGWL_GAIN_W-1:0] cdb(input logic [7:0] c);
		int h = 0;
		for (int i = 0; i < 8; i++) if (c[i]) h = i + 1;
		return SGWL_GAIN_W'(SGWL_GAIN_MIN_CDB + SGWL_GAIN_STEP_CDB * h);
	endfunction : cdb
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic results();
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	// Old content shifts up, so short loads expose stray shifting
	task automatic do_load(input logic [15:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) sr = {sr[6:0], w[i]};
		q.push_back(sr);
		HOST.load(w, n);
		for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge mclk_i);
		if (q.size() > 0) begin
			`CHK("load_done", 0, q.size())
			results();
		end
	endtask : do_load
	always @(posedge mclk_i) begin
		if (load_done_o === 1'h1 && q.size() == 0) begin
			`CHK("spare_load", 1'h0, load_done_o)
		end else if (load_done_o === 1'h1) begin
			`CHK("code", q[0], gain_code_o)
			`CHK("cdb", cdb(q[0]), gain_cdb_o)
			void'(q.pop_front());
		end
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge mclk_i);
		`CHK("rst", {8'h00, cdb(8'h00)}, {gain_code_o, gain_cdb_o})
		for (int k = 0; k < 9; k++) do_load(16'h0080 >> (8 - k), 8);
		`CHK("tx", 1'h0, tx_active_o)
		HOST.tx(1'h1);
		repeat (5) @(posedge mclk_i);
		`CHK("tx", 1'h1, tx_active_o)
		for (int k = 0; k < 6; k++) do_load(16'(xs()), 8 + k % 3 * 2);
		// Mid-run reset clears the latch and the shift register
		rst_i <= 1'h1;
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'h0;
		sr = 8'h00;
		repeat (4) @(posedge mclk_i);
		`CHK("rst2", {8'h00, cdb(8'h00)}, {gain_code_o, gain_cdb_o})
		HOST.stray(3);
		do_load(16'h0005, 4);
		results();
	end
endmodule : testbench
